// ---- decskip_pkg.sv ----
// package: constants for the decrement-and-skip instruction logic
package decskip_pkg;

    // ------------------------------------------------------------------
    // instruction word layout
    // ------------------------------------------------------------------
    localparam int          OPC_HI         = 15;
    localparam int          OPC_LO         = 10;
    localparam int          DEST_BIT       = 9;
    localparam int          ACC_BIT        = 8;
    localparam logic [5:0]  OPC_DEC_SKZ    = 6'h0_0b;
    localparam logic [5:0]  OPC_DEC_SKNZ   = 6'h0_13;

    // ------------------------------------------------------------------
    // addressing
    // ------------------------------------------------------------------
    localparam logic [7:0]  IDX_LIMIT      = 8'h5f;
    localparam logic [7:0]  ACC_SPLIT      = 8'h60;
    localparam logic [3:0]  ACC_HI_BANK    = 4'hf;
    localparam logic [7:0]  RESULT_ZERO    = 8'h00;
    localparam logic [7:0]  ONE            = 8'h01;

    // ------------------------------------------------------------------
    // cycle costs, in instruction cycles
    // ------------------------------------------------------------------
    localparam logic [1:0]  CYC_NO_SKIP    = 2'h1;
    localparam logic [1:0]  CYC_SKIP_ONE   = 2'h2;
    localparam logic [1:0]  CYC_SKIP_TWO   = 2'h3;

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_NOP1, ST_NOP2} phase_t;

endpackage : decskip_pkg

// ---- decskip_addr.sv ----
// module: effective data-memory address generation for the byte instructions
`timescale 1ns/10ps
module decskip_addr
(
    // operand fields
    input  wire logic [7:0]  f_addr,
    input  wire logic        access_sel,
    input  wire logic        ext_set_en,
    // bank and index state
    input  wire logic [3:0]  bank_pointer_reg,
    input  wire logic [11:0] index_base,
    // result
    output logic      [11:0] eff_addr,
    output logic             indexed
);

    // ------------------------------------------------------------------
    // address select
    // ------------------------------------------------------------------
    wire logic        use_idx;
    wire logic [11:0] idx_addr;
    wire logic [11:0] acc_addr;
    wire logic [11:0] bank_addr;

    // indexed offset mode wins over the access bank only for low offsets
    assign use_idx   = ext_set_en && !access_sel && (f_addr <= decskip_pkg::IDX_LIMIT);
    assign idx_addr  = index_base + {4'h0, f_addr};
    // access bank offsets below 60h map to bank 0, the rest to the top bank
    assign acc_addr  = (f_addr < decskip_pkg::ACC_SPLIT) ? {4'h0, f_addr}
                                                         : {decskip_pkg::ACC_HI_BANK, f_addr};
    assign bank_addr = {bank_pointer_reg, f_addr};
    assign eff_addr  = use_idx ? idx_addr : (access_sel ? bank_addr : acc_addr);
    assign indexed   = use_idx;

endmodule : decskip_addr

// ---- decrement_skip_instr.sv ----
// module: decode and execute of the two decrement-and-skip instructions
// Summary of operation
// - read addressed register and subtract one
// - destination bit 0 writes result into accumulator, register untouched
// - destination bit 1 writes result back into the addressed register
// - skip-if-zero discards next instruction when result is zero
// - skip-if-nonzero discards next instruction when result is not zero
// - taken skip costs two cycles, no skip costs one
// - skipping a two-word instruction costs three cycles
// - bank bit 0 uses access bank, 1 uses bank pointer register
// - extended set, bank bit clear, address up to 95 selects indexed offset
`timescale 1ns/10ps
module decrement_skip_instr
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        srst,
    // instruction stream
    input  wire logic        instr_valid,
    input  wire logic [15:0] instr_word,
    input  wire logic        next_two_word,
    // configuration and bank state
    input  wire logic        ext_set_en,
    input  wire logic [3:0]  bank_pointer_reg,
    input  wire logic [11:0] index_base,
    // data memory read port
    output logic      [11:0] mem_addr,
    input  wire logic [7:0]  mem_rdata,
    // data memory write port
    output logic             mem_we,
    output logic      [7:0]  mem_wdata,
    // accumulator write port
    output logic             acc_we,
    output logic      [7:0]  acc_wdata,
    // status and sequencing
    output logic             busy,
    output logic             skip_nop,
    output logic             done,
    output logic      [1:0]  cycles_used,
    output logic             flags_we
);

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire logic        is_skz;
    wire logic        is_sknz;
    wire logic        is_ours;
    wire logic        dest_reg;
    wire logic [11:0] eff_addr;
    wire logic        eff_indexed;

    // only the two opcodes of this block are accepted
    assign is_skz   = instr_word[decskip_pkg::OPC_HI:decskip_pkg::OPC_LO] == decskip_pkg::OPC_DEC_SKZ;
    assign is_sknz  = instr_word[decskip_pkg::OPC_HI:decskip_pkg::OPC_LO] == decskip_pkg::OPC_DEC_SKNZ;
    assign is_ours  = instr_valid && (is_skz || is_sknz);
    assign dest_reg = instr_word[decskip_pkg::DEST_BIT];

    decskip_addr u_addr
    (
        .f_addr           (instr_word[7:0]),
        .access_sel       (instr_word[decskip_pkg::ACC_BIT]),
        .ext_set_en       (ext_set_en),
        .bank_pointer_reg (bank_pointer_reg),
        .index_base       (index_base),
        .eff_addr         (eff_addr),
        .indexed          (eff_indexed)
    );

    // ------------------------------------------------------------------
    // latched instruction state
    // ------------------------------------------------------------------
    decskip_pkg::phase_t phase;
    decskip_pkg::phase_t next_phase;
    logic              held_skz;
    logic              held_dest;
    logic              held_two;

    // capture on accept so the operand stays stable while memory answers
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            held_skz  <= 1'b0;
            held_dest <= 1'b0;
            held_two  <= 1'b0;
        end
        else if (phase == decskip_pkg::ST_IDLE && is_ours)
        begin
            held_skz  <= is_skz;
            held_dest <= dest_reg;
            held_two  <= next_two_word;
        end
    end

    // ------------------------------------------------------------------
    // execute arithmetic and skip decision
    // ------------------------------------------------------------------
    wire logic [7:0] result;
    wire logic       res_zero;
    wire logic       take_skip;

    // 8-bit subtract wraps 00 to ff, which then reads as non-zero
    assign result    = mem_rdata - decskip_pkg::ONE;
    assign res_zero  = (result == decskip_pkg::RESULT_ZERO);
    assign take_skip = held_skz ? res_zero : !res_zero;

    // ------------------------------------------------------------------
    // sequencer: one cycle to execute, then on a skip one or two forced no-ops
    // ------------------------------------------------------------------
    // a write happens even when the following word is skipped
    always_comb
    begin
        next_phase = phase;
        unique case (phase)
            decskip_pkg::ST_IDLE: if (is_ours) next_phase = decskip_pkg::ST_EXEC;
            decskip_pkg::ST_EXEC: next_phase = take_skip ? decskip_pkg::ST_NOP1 : decskip_pkg::ST_IDLE;
            decskip_pkg::ST_NOP1: next_phase = held_two ? decskip_pkg::ST_NOP2 : decskip_pkg::ST_IDLE;
            decskip_pkg::ST_NOP2: next_phase = decskip_pkg::ST_IDLE;
        endcase
    end

    // phase register; requests arriving outside idle are simply not taken
    always_ff @(posedge clock)
    begin
        if (srst)
            phase <= decskip_pkg::ST_IDLE;
        else
            phase <= next_phase;
    end

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    wire logic exec_now;
    wire logic finish_now;
    wire logic [1:0] next_cycles;

    assign exec_now    = (phase == decskip_pkg::ST_EXEC);
    assign finish_now  = (phase != decskip_pkg::ST_IDLE) && (next_phase == decskip_pkg::ST_IDLE);
    assign next_cycles = (phase == decskip_pkg::ST_EXEC) ? decskip_pkg::CYC_NO_SKIP
                       : (phase == decskip_pkg::ST_NOP1) ? decskip_pkg::CYC_SKIP_ONE
                       : decskip_pkg::CYC_SKIP_TWO;

    // write strobes are one-cycle pulses, issued as the execute cycle ends
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            mem_addr    <= 12'h0_000;
            mem_we      <= 1'b0;
            mem_wdata   <= 8'h00;
            acc_we      <= 1'b0;
            acc_wdata   <= 8'h00;
            busy        <= 1'b0;
            skip_nop    <= 1'b0;
            done        <= 1'b0;
            cycles_used <= 2'h0;
            flags_we    <= 1'b0;
        end
        else
        begin
            mem_addr    <= (phase == decskip_pkg::ST_IDLE && is_ours) ? eff_addr : mem_addr;
            mem_we      <= exec_now && held_dest;
            mem_wdata   <= result;
            acc_we      <= exec_now && !held_dest;
            acc_wdata   <= result;
            busy        <= next_phase != decskip_pkg::ST_IDLE;
            skip_nop    <= next_phase == decskip_pkg::ST_NOP1 || next_phase == decskip_pkg::ST_NOP2;
            done        <= finish_now;
            cycles_used <= finish_now ? next_cycles : cycles_used;
            flags_we    <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_exec_skip;
        phase == decskip_pkg::ST_EXEC && take_skip;
    endsequence

    a_zero_skip_taken: assert property (@(posedge clock) disable iff (srst)
        exec_now && held_skz && res_zero |=> skip_nop)
        else $error("skip-if-zero did not skip");
    a_nonzero_skip_taken: assert property (@(posedge clock) disable iff (srst)
        exec_now && !held_skz && !res_zero |=> skip_nop)
        else $error("skip-if-nonzero did not skip");
    a_no_skip_quiet: assert property (@(posedge clock) disable iff (srst)
        exec_now && !take_skip |=> !skip_nop)
        else $error("no-op forced without skip");
    a_no_skip_one: assert property (@(posedge clock) disable iff (srst)
        exec_now && !take_skip |=> done && cycles_used == decskip_pkg::CYC_NO_SKIP)
        else $error("no-skip cost wrong");
    a_skip_two_cycles: assert property (@(posedge clock) disable iff (srst)
        s_exec_skip ##0 !held_two |=> ##1 done && cycles_used == decskip_pkg::CYC_SKIP_ONE)
        else $error("skip cost wrong");
    a_skip_three_cycles: assert property (@(posedge clock) disable iff (srst)
        s_exec_skip ##0 held_two |=> skip_nop[*2] ##1 done && cycles_used == decskip_pkg::CYC_SKIP_TWO)
        else $error("long skip wrong");
    a_busy_done_low: assert property (@(posedge clock) disable iff (srst)
        done |-> !busy)
        else $error("busy still high at done");
    a_dest_acc_only: assert property (@(posedge clock) disable iff (srst)
        exec_now && !held_dest |=> acc_we && !mem_we && acc_wdata == $past(result))
        else $error("acc write wrong");
    a_dest_reg_only: assert property (@(posedge clock) disable iff (srst)
        exec_now && held_dest |=> mem_we && !acc_we && mem_wdata == $past(result))
        else $error("reg write wrong");
    a_decrement_wraps: assert property (@(posedge clock) disable iff (srst)
        exec_now && mem_rdata == decskip_pkg::RESULT_ZERO |-> result == 8'hff && !res_zero)
        else $error("wrap wrong");
    a_flags_untouched: assert property (@(posedge clock) disable iff (srst)
        !flags_we)
        else $error("status flags written");
    a_index_select: assert property (@(posedge clock) disable iff (srst)
        ext_set_en && !instr_word[decskip_pkg::ACC_BIT] && instr_word[7:0] <= decskip_pkg::IDX_LIMIT |-> eff_indexed)
        else $error("indexed mode missed");
    a_bank_select: assert property (@(posedge clock) disable iff (srst)
        instr_word[decskip_pkg::ACC_BIT] |-> eff_addr == {bank_pointer_reg, instr_word[7:0]})
        else $error("bank select wrong");
    a_decode_accept: assert property (@(posedge clock) disable iff (srst)
        phase == decskip_pkg::ST_IDLE && instr_valid
        && instr_word[decskip_pkg::OPC_HI:decskip_pkg::OPC_LO] == decskip_pkg::OPC_DEC_SKZ |=> exec_now && held_skz)
        else $error("decode wrong");
    a_decode_nonzero: assert property (@(posedge clock) disable iff (srst)
        phase == decskip_pkg::ST_IDLE && instr_valid
        && instr_word[decskip_pkg::OPC_HI:decskip_pkg::OPC_LO] == decskip_pkg::OPC_DEC_SKNZ |=> exec_now && !held_skz)
        else $error("nonzero decode wrong");

endmodule : decrement_skip_instr

// ---- decrement_skip_instr_bench.sv ----
// testbench: self-checking run of the decrement-and-skip instruction logic
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_errors++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module decrement_skip_instr_bench;
    // ------------------------------------------------------------------
    // design hookup
    // ------------------------------------------------------------------
    logic        clock, srst, instr_valid, next_two_word, ext_set_en;
    logic [15:0] instr_word;
    logic [3:0]  bank_pointer_reg;
    logic [11:0] index_base, mem_addr;
    logic [7:0]  mem_rdata, mem_wdata, acc_wdata;
    logic        mem_we, acc_we, busy, skip_nop, done, flags_we;
    logic [1:0]  cycles_used;
    int          n_errors, checks_done, n_cyc;

    decrement_skip_instr u_decrement_skip_instr (.clock(clock), .srst(srst), .instr_valid(instr_valid),
        .instr_word(instr_word), .next_two_word(next_two_word), .ext_set_en(ext_set_en),
        .bank_pointer_reg(bank_pointer_reg), .index_base(index_base), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata), .mem_we(mem_we), .mem_wdata(mem_wdata), .acc_we(acc_we),
        .acc_wdata(acc_wdata), .busy(busy), .skip_nop(skip_nop), .done(done),
        .cycles_used(cycles_used), .flags_we(flags_we));

    // clock and a hang guard well above the few dozen cycles the tests need
    always #2 clock = ~clock;
    always @(posedge clock)
    begin
        n_cyc++;
        if (n_cyc == 2000)
        begin
            n_errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------------
    // expected effective address, worked out independently of the design
    // ------------------------------------------------------------------
    function automatic logic [11:0] exp_addr(input logic a, input logic ext, input logic [7:0] f);
        if (a)
            return {bank_pointer_reg, f};
        else if (ext && f <= 8'h5f)
            return index_base + {4'h0, f};
        else if (f < 8'h60)
            return {4'h0, f};
        else
            return {4'hf, f};
    endfunction : exp_addr

    // one instruction: issue, watch every cycle until done, compare effects
    task automatic run(input logic [5:0] opc, input logic d, input logic a, input logic [7:0] f,
                       input logic [7:0] rd, input logic two, input logic ext);
        logic [7:0] res;
        logic       skip;
        int         k, n_acc, n_mem, n_nop;
        res = rd - 8'h01;
        skip = (opc == 6'h0b) ? (res == 8'h00) : (res != 8'h00);
        k = skip ? (two ? 4 : 3) : 2;
        n_acc = 0;
        n_mem = 0;
        n_nop = 0;
        @(posedge clock);
        #1;
        instr_word = {opc, d, a, f};
        next_two_word = two;
        ext_set_en = ext;
        mem_rdata = rd;
        instr_valid = 1'b1;
        @(posedge clock);
        #1;
        instr_valid = 1'b0;
        `CHK("mem_addr", exp_addr(a, ext, f), mem_addr)
        `CHK("busy", 1'b1, busy)
        for (int i = 2; i < 7; i++)
        begin
            @(posedge clock);
            #1;
            `CHK("flags_we", 1'b0, flags_we)
            if (acc_we === 1'b1)
            begin
                n_acc++;
                `CHK("acc_wdata", res, acc_wdata)
            end
            if (mem_we === 1'b1)
            begin
                n_mem++;
                `CHK("mem_wdata", res, mem_wdata)
            end
            if (skip_nop === 1'b1)
                n_nop++;
            if (done === 1'b1)
            begin
                `CHK("done_cycle", k, i)
                `CHK("busy_at_done", 1'b0, busy)
                break;
            end
        end
        `CHK("acc_we_count", d ? 0 : 1, n_acc)
        `CHK("mem_we_count", d ? 1 : 0, n_mem)
        `CHK("skip_nop_count", k - 2, n_nop)
        `CHK("cycles_used", k[1:0] - 2'h1, cycles_used)
        $display("test opc %h f %h data %h finished", opc, f, rd);
    endtask : run

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        clock = 1'b0;
        srst = 1'b1;
        instr_valid = 1'b0;
        instr_word = 16'h0000;
        next_two_word = 1'b0;
        ext_set_en = 1'b0;
        bank_pointer_reg = 4'h5;
        index_base = 12'h1_a0;
        mem_rdata = 8'h00;
        n_errors = 0;
        checks_done = 0;
        n_cyc = 0;
        repeat (4) @(posedge clock);
        #1;
        srst = 1'b0;
        // skip-if-zero: skip taken, plain, wrap-around, two-word skip
        run(6'h0b, 1'b1, 1'b1, 8'h23, 8'h01, 1'b0, 1'b0);
        run(6'h0b, 1'b0, 1'b0, 8'h10, 8'h05, 1'b1, 1'b0);
        run(6'h0b, 1'b1, 1'b0, 8'h5f, 8'h00, 1'b0, 1'b1);
        run(6'h0b, 1'b0, 1'b1, 8'hff, 8'h01, 1'b1, 1'b1);
        // skip-if-nonzero: wrap skips over two words, zero result falls through
        run(6'h13, 1'b1, 1'b0, 8'h00, 8'h00, 1'b1, 1'b1);
        run(6'h13, 1'b0, 1'b0, 8'h60, 8'h01, 1'b0, 1'b1);
        run(6'h13, 1'b1, 1'b0, 8'h20, 8'h80, 1'b0, 1'b0);
        // a foreign opcode must be ignored without any activity
        @(posedge clock);
        #1;
        instr_word = 16'h2c_45 ^ 16'h0400;
        instr_valid = 1'b1;
        repeat (3)
        begin
            @(posedge clock);
            #1;
            `CHK("ignored_busy", 1'b0, busy | mem_we | acc_we | done)
        end
        instr_valid = 1'b0;
        $display("test foreign opcode finished");
        end_sim();
    end
endmodule : decrement_skip_instr_bench
